// >>> rtl/iomcr_pkg.sv
/*
 * Package for the I/O memory control register bank: offsets, field positions and reset values.
 * Assumes a 4-bit data-memory bus whose low byte of address selects the I/O word.
 */
package iomcr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 4;
    localparam logic [7:0] OFF_TIMER_FLAG = 8'hc0;
    localparam logic [7:0] OFF_SERIAL_FLAG = 8'hc1;
    localparam logic [7:0] OFF_PORT1_FLAG = 8'hc2;
    localparam logic [7:0] OFF_PORT0_FLAG = 8'hc3;
    localparam logic [7:0] OFF_CONV_FLAG = 8'hc4;
    localparam logic [7:0] OFF_SW_FLAGS = 8'hc5;
    localparam logic [7:0] OFF_CT_FLAGS = 8'hc6;
    localparam logic [7:0] OFF_PERIPH_MASK = 8'hc8;
    localparam logic [7:0] OFF_PORT_MASK = 8'hc9;
    localparam logic [7:0] OFF_P0_SELECT = 8'hca;
    localparam logic [7:0] OFF_SW_MASK = 8'hcb;
    localparam logic [7:0] OFF_CT_MASK = 8'hcc;
    localparam logic [7:0] OFF_BUZZER = 8'he0;
    localparam logic [7:0] OFF_FREQ_OUT = 8'he1;
    localparam logic [7:0] OFF_CT_RESET = 8'he2;
    localparam logic [7:0] OFF_CT_LOW = 8'he3;
    localparam logic [7:0] OFF_CT_HIGH = 8'he4;
    localparam logic [7:0] OFF_WATCHDOG = 8'he5;
    localparam logic [7:0] OFF_SW_CTRL = 8'he6;
    localparam logic [7:0] OFF_SW_HUND = 8'he7;
    localparam logic [7:0] OFF_SW_TENTH = 8'he8;
    localparam logic [7:0] OFF_PT_CTRL = 8'he9;
    localparam logic [7:0] OFF_PT_CONFIG = 8'hea;
    localparam logic [7:0] OFF_PT_CNT_LO = 8'heb;
    localparam logic [7:0] OFF_PT_CNT_HI = 8'hec;
    localparam logic [7:0] OFF_PT_RLD_LO = 8'hed;
    localparam logic [7:0] OFF_PT_RLD_HI = 8'hee;
    localparam logic [7:0] OFF_LCD = 8'hef;
    localparam logic [1:0] IO_BASE_TOP = 2'h3;
    localparam int BIT_D0 = 0;
    localparam int BIT_D1 = 1;
    localparam int BIT_D2 = 2;
    localparam int BIT_D3 = 3;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
    localparam logic [1:0] RST_FIELD2 = 2'h0;
    localparam logic [7:0] RST_BYTE = 8'h00;
endpackage

// >>> rtl/iomcr_regs.sv
/*
 * I/O memory control register bank: interrupt factor flags, masks, and the control,
 * readback and configuration registers of the buzzer, clock timer, watchdog,
 * stopwatch, programmable timer and LCD.
 * Assumes the CPU completes each access in one clock, with mem_rd or mem_wr high for
 * that cycle only, and that the peripherals send one-cycle event pulses and live state.
 */
// Overview of operation
// R1: Reading an event flag returns it, then clears it in the same access.
// R2: Single flags in D0 at C0H-C4H: timer, serial, port1, port0, converter.
// R3: Stopwatch flags at C5H: D1 is 1 Hz, D0 is 10 Hz, reset 0.
// R4: Clock timer flags at C6H: D3 1 Hz, D2 2 Hz, D1 8 Hz, D0 32 Hz.
// R5: Peripheral mask C8H: D2 converter, D1 serial, D0 timer; D3 reads 0.
// R6: Port mask C9H: D1 port1, D0 port0; upper bits unused.
// R7: Port0 line select CAH: one bit per input line, 1 joins the interrupt.
// R8: Stopwatch mask CBH: D1 for 1 Hz, D0 for 10 Hz.
// R9: Clock timer mask CCH: four enables matching the clock timer flags.
// R10: Buzzer control: D3, D2 route outputs 3, 2 to buzzer; D0 picks 2 kHz.
// R11: Frequency output E1H: D3 routes output 0; D1-D0 pick source frequency.
// R12: Writing 1 to E2H D0 resets clock timer and watchdog; reads 0.
// R13: E3H and E4H read back the eight clock timer divider stages.
// R14: E5H D3 write 1 resets watchdog; D1, D0 show its stages.
// R15: E6H D1 runs the stopwatch; D0 write 1 clears its count.
// R16: E7H and E8H read the stopwatch hundredths and tenths BCD digits.
// R17: E9H D3 routes output 1 to overflow, D1 runs, D0 reloads timer.
// R18: EAH D3-D2 select timer pre-divider 1/256, 1/32, 1/4, 1/1.
// R19: EAH D1-D0 select timer source: filtered-off port1, port1, low, high.
// R20: Timer count is read-only, low nibble EBH, high nibble ECH.
// R21: Timer reload value is read/write at EDH and EEH.
// R22: EFH holds LCD duty in D3-D2 and display-on in D0.
// R23: Unused bits read 0 and ignore writes.
// R24: The bank answers at C0H-FFH of every data-memory page.
// R25: Events set flags; interrupt request when any enabled flag is set.
// R26: Each access takes one cycle; writes apply then, reads return the word.
`timescale 1ns/1ns
`default_nettype none
module iomcr_regs
    import iomcr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [9:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [3:0] mem_wdata,
    output logic [3:0] mem_rdata,
    output logic mem_sel,
    input wire logic timer_event,
    input wire logic serial_event,
    input wire logic port1_event,
    input wire logic port0_event,
    input wire logic converter_event,
    input wire logic [1:0] stopwatch_events,
    input wire logic [3:0] clock_timer_events,
    input wire logic [7:0] clock_stages,
    input wire logic [1:0] watchdog_stages,
    input wire logic [3:0] stopwatch_hundredths,
    input wire logic [3:0] stopwatch_tenths,
    input wire logic [7:0] timer_count,
    output logic irq_request,
    output logic [2:0] periph_irq_enable,
    output logic [1:0] port_irq_enable,
    output logic [3:0] port0_line_select,
    output logic [1:0] stopwatch_irq_enable,
    output logic [3:0] clock_timer_irq_enable,
    output logic out3_buzzer_route,
    output logic out2_buzzer_route,
    output logic buzzer_tone_select,
    output logic out0_freq_route,
    output logic [1:0] freq_output_select,
    output logic clock_timer_reset_strobe,
    output logic watchdog_reset_strobe,
    output logic stopwatch_run,
    output logic stopwatch_clear_strobe,
    output logic out1_overflow_route,
    output logic timer_run,
    output logic timer_reload_strobe,
    output logic [1:0] timer_prediv,
    output logic [1:0] timer_source,
    output logic [7:0] timer_reload,
    output logic [1:0] lcd_duty,
    output logic lcd_display_on
);

    // =========================================================================
    // Address decode
    // =========================================================================
    logic [7:0] off;
    logic io_hit;
    logic rd_hit;
    logic wr_hit;

    assign off = mem_addr[7:0];
    assign io_hit = (off[7:6] == IO_BASE_TOP); // R24
    assign rd_hit = mem_rd && io_hit;
    assign wr_hit = mem_wr && io_hit; // R26
    assign mem_sel = io_hit && (mem_rd || mem_wr);

    function automatic logic wr_at(input logic [7:0] a);
        wr_at = wr_hit && (off == a);
    endfunction

    function automatic logic rd_at(input logic [7:0] a);
        rd_at = rd_hit && (off == a);
    endfunction

    // =========================================================================
    // Interrupt factor flags
    // =========================================================================
    logic timer_flag_r;
    logic serial_flag_r;
    logic port1_flag_r;
    logic port0_flag_r;
    logic conv_flag_r;
    logic [1:0] sw_flags_r;
    logic [3:0] ct_flags_r;

    // Set wins over the clear-on-read in the same cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            timer_flag_r <= 1'b0;
            serial_flag_r <= 1'b0;
            port1_flag_r <= 1'b0;
            port0_flag_r <= 1'b0;
            conv_flag_r <= 1'b0;
            sw_flags_r <= RST_FIELD2;
            ct_flags_r <= RST_NIBBLE;
        end else begin
            timer_flag_r <= timer_event | (timer_flag_r & ~rd_at(OFF_TIMER_FLAG)); // R1 R2 R25
            serial_flag_r <= serial_event | (serial_flag_r & ~rd_at(OFF_SERIAL_FLAG)); // R1 R2 R25
            port1_flag_r <= port1_event | (port1_flag_r & ~rd_at(OFF_PORT1_FLAG)); // R1 R2 R25
            port0_flag_r <= port0_event | (port0_flag_r & ~rd_at(OFF_PORT0_FLAG)); // R1 R2 R25
            conv_flag_r <= converter_event | (conv_flag_r & ~rd_at(OFF_CONV_FLAG)); // R1 R2 R25
            sw_flags_r <= stopwatch_events | (sw_flags_r & {2{~rd_at(OFF_SW_FLAGS)}}); // R1 R3 R25
            ct_flags_r <= clock_timer_events | (ct_flags_r & {4{~rd_at(OFF_CT_FLAGS)}}); // R1 R4 R25
        end
    end

    // =========================================================================
    // Mask and selection registers
    // =========================================================================
    always_ff @(posedge clock) begin
        if (rst) begin
            periph_irq_enable <= 3'h0;
            port_irq_enable <= RST_FIELD2;
            port0_line_select <= RST_NIBBLE;
            stopwatch_irq_enable <= RST_FIELD2;
            clock_timer_irq_enable <= RST_NIBBLE;
        end else begin
            if (wr_at(OFF_PERIPH_MASK)) begin
                periph_irq_enable <= mem_wdata[2:0]; // R5 R23
            end
            if (wr_at(OFF_PORT_MASK)) begin
                port_irq_enable <= mem_wdata[1:0]; // R6 R23
            end
            if (wr_at(OFF_P0_SELECT)) begin
                port0_line_select <= mem_wdata; // R7
            end
            if (wr_at(OFF_SW_MASK)) begin
                stopwatch_irq_enable <= mem_wdata[1:0]; // R8 R23
            end
            if (wr_at(OFF_CT_MASK)) begin
                clock_timer_irq_enable <= mem_wdata; // R9
            end
        end
    end

    assign irq_request = |{timer_flag_r & periph_irq_enable[BIT_D0],
                           serial_flag_r & periph_irq_enable[BIT_D1],
                           conv_flag_r & periph_irq_enable[BIT_D2],
                           port1_flag_r & port_irq_enable[BIT_D1],
                           port0_flag_r & port_irq_enable[BIT_D0],
                           sw_flags_r & stopwatch_irq_enable,
                           ct_flags_r & clock_timer_irq_enable}; // R25

    // =========================================================================
    // Output routing and peripheral control
    // =========================================================================
    always_ff @(posedge clock) begin
        if (rst) begin
            out3_buzzer_route <= 1'b0;
            out2_buzzer_route <= 1'b0;
            buzzer_tone_select <= 1'b0;
            out0_freq_route <= 1'b0;
            freq_output_select <= RST_FIELD2;
            stopwatch_run <= 1'b0;
            out1_overflow_route <= 1'b0;
            timer_run <= 1'b0;
            timer_prediv <= RST_FIELD2;
            timer_source <= RST_FIELD2;
            lcd_duty <= RST_FIELD2;
            lcd_display_on <= 1'b0;
        end else begin
            if (wr_at(OFF_BUZZER)) begin
                out3_buzzer_route <= mem_wdata[BIT_D3]; // R10
                out2_buzzer_route <= mem_wdata[BIT_D2]; // R10
                buzzer_tone_select <= mem_wdata[BIT_D0]; // R10
            end
            if (wr_at(OFF_FREQ_OUT)) begin
                out0_freq_route <= mem_wdata[BIT_D3]; // R11
                freq_output_select <= mem_wdata[1:0]; // R11
            end
            if (wr_at(OFF_SW_CTRL)) begin
                stopwatch_run <= mem_wdata[BIT_D1]; // R15
            end
            if (wr_at(OFF_PT_CTRL)) begin
                out1_overflow_route <= mem_wdata[BIT_D3]; // R17
                timer_run <= mem_wdata[BIT_D1]; // R17
            end
            if (wr_at(OFF_PT_CONFIG)) begin
                timer_prediv <= mem_wdata[3:2]; // R18
                timer_source <= mem_wdata[1:0]; // R19
            end
            if (wr_at(OFF_LCD)) begin
                lcd_duty <= mem_wdata[3:2]; // R22
                lcd_display_on <= mem_wdata[BIT_D0]; // R22
            end
        end
    end

    // Reload value has no defined reset; cleared anyway for a clean start
    always_ff @(posedge clock) begin
        if (rst) begin
            timer_reload <= RST_BYTE;
        end else begin
            if (wr_at(OFF_PT_RLD_LO)) begin
                timer_reload[3:0] <= mem_wdata; // R21
            end
            if (wr_at(OFF_PT_RLD_HI)) begin
                timer_reload[7:4] <= mem_wdata; // R21
            end
        end
    end

    // =========================================================================
    // Write-only strobes, one cycle after the write
    // =========================================================================
    always_ff @(posedge clock) begin
        if (rst) begin
            clock_timer_reset_strobe <= 1'b0;
            watchdog_reset_strobe <= 1'b0;
            stopwatch_clear_strobe <= 1'b0;
            timer_reload_strobe <= 1'b0;
        end else begin
            clock_timer_reset_strobe <= wr_at(OFF_CT_RESET) && mem_wdata[BIT_D0]; // R12
            watchdog_reset_strobe <= (wr_at(OFF_WATCHDOG) && mem_wdata[BIT_D3])
                                     || (wr_at(OFF_CT_RESET) && mem_wdata[BIT_D0]); // R12 R14
            stopwatch_clear_strobe <= wr_at(OFF_SW_CTRL) && mem_wdata[BIT_D0]; // R15
            timer_reload_strobe <= wr_at(OFF_PT_CTRL) && mem_wdata[BIT_D0]; // R17
        end
    end

    // =========================================================================
    // Read multiplexer (combinational, same cycle)
    // =========================================================================
    always_comb begin
        mem_rdata = 4'h0; // R23
        if (rd_hit) begin
            case (off)
                OFF_TIMER_FLAG: mem_rdata = {3'h0, timer_flag_r}; // R2
                OFF_SERIAL_FLAG: mem_rdata = {3'h0, serial_flag_r}; // R2
                OFF_PORT1_FLAG: mem_rdata = {3'h0, port1_flag_r}; // R2
                OFF_PORT0_FLAG: mem_rdata = {3'h0, port0_flag_r}; // R2
                OFF_CONV_FLAG: mem_rdata = {3'h0, conv_flag_r}; // R2
                OFF_SW_FLAGS: mem_rdata = {2'h0, sw_flags_r}; // R3
                OFF_CT_FLAGS: mem_rdata = ct_flags_r; // R4
                OFF_PERIPH_MASK: mem_rdata = {1'b0, periph_irq_enable}; // R5
                OFF_PORT_MASK: mem_rdata = {2'h0, port_irq_enable}; // R6
                OFF_P0_SELECT: mem_rdata = port0_line_select; // R7
                OFF_SW_MASK: mem_rdata = {2'h0, stopwatch_irq_enable}; // R8
                OFF_CT_MASK: mem_rdata = clock_timer_irq_enable; // R9
                OFF_BUZZER: mem_rdata = {out3_buzzer_route, out2_buzzer_route, 1'b0, buzzer_tone_select}; // R10
                OFF_FREQ_OUT: mem_rdata = {out0_freq_route, 1'b0, freq_output_select}; // R11
                OFF_CT_RESET: mem_rdata = 4'h0; // R12
                OFF_CT_LOW: mem_rdata = clock_stages[3:0]; // R13
                OFF_CT_HIGH: mem_rdata = clock_stages[7:4]; // R13
                OFF_WATCHDOG: mem_rdata = {2'h0, watchdog_stages}; // R14
                OFF_SW_CTRL: mem_rdata = {2'h0, stopwatch_run, 1'b0}; // R15
                OFF_SW_HUND: mem_rdata = stopwatch_hundredths; // R16
                OFF_SW_TENTH: mem_rdata = stopwatch_tenths; // R16
                OFF_PT_CTRL: mem_rdata = {out1_overflow_route, 1'b0, timer_run, 1'b0}; // R17
                OFF_PT_CONFIG: mem_rdata = {timer_prediv, timer_source}; // R18 R19
                OFF_PT_CNT_LO: mem_rdata = timer_count[3:0]; // R20
                OFF_PT_CNT_HI: mem_rdata = timer_count[7:4]; // R20
                OFF_PT_RLD_LO: mem_rdata = timer_reload[3:0]; // R21
                OFF_PT_RLD_HI: mem_rdata = timer_reload[7:4]; // R21
                OFF_LCD: mem_rdata = {lcd_duty, 1'b0, lcd_display_on}; // R22
                default: mem_rdata = 4'h0;
            endcase
        end
    end

    // =========================================================================
    // Checks
    // =========================================================================
    // Flag set and clear
    a_flag_read_clear: assert property (@(posedge clock) disable iff (rst) // R1
        rd_at(OFF_TIMER_FLAG) && !timer_event |=> !timer_flag_r)
        else $error("timer flag not cleared by read");

    a_flag_set_wins: assert property (@(posedge clock) disable iff (rst) // R25
        timer_event |=> timer_flag_r)
        else $error("timer flag lost its event");

    a_flag_read_value: assert property (@(posedge clock) disable iff (rst) // R2
        rd_at(OFF_SERIAL_FLAG) |-> mem_rdata == {3'h0, serial_flag_r})
        else $error("serial flag read mismatch");

    a_ct_flags_hold: assert property (@(posedge clock) disable iff (rst) // R4
        ct_flags_r[BIT_D3] && !rd_at(OFF_CT_FLAGS) |=> ct_flags_r[BIT_D3])
        else $error("clock flag lost without a read");

    // Interrupt request
    a_irq_from_mask: assert property (@(posedge clock) disable iff (rst) // R25
        conv_flag_r && periph_irq_enable[BIT_D2] |-> irq_request)
        else $error("enabled flag gave no request");

    a_irq_masked: assert property (@(posedge clock) disable iff (rst) // R5
        periph_irq_enable == 3'h0 && port_irq_enable == 2'h0 && stopwatch_irq_enable == 2'h0
        && clock_timer_irq_enable == 4'h0 |-> !irq_request)
        else $error("request while all masked");

    // Register writes and strobes
    a_mask_write: assert property (@(posedge clock) disable iff (rst) // R9
        wr_at(OFF_CT_MASK) |=> clock_timer_irq_enable == $past(mem_wdata))
        else $error("mask write not applied");

    a_wd_strobe: assert property (@(posedge clock) disable iff (rst) // R12
        wr_at(OFF_CT_RESET) && mem_wdata[BIT_D0] |=> clock_timer_reset_strobe && watchdog_reset_strobe)
        else $error("timer reset strobe missing");

    a_strobe_one_cycle: assert property (@(posedge clock) disable iff (rst) // R12
        !(wr_at(OFF_CT_RESET) && mem_wdata[BIT_D0]) |=> !clock_timer_reset_strobe)
        else $error("timer reset strobe without a write");

    a_wd_direct: assert property (@(posedge clock) disable iff (rst) // R14
        wr_at(OFF_WATCHDOG) && mem_wdata[BIT_D3] |=> watchdog_reset_strobe)
        else $error("watchdog reset strobe missing");

    a_sw_clear: assert property (@(posedge clock) disable iff (rst) // R15
        wr_at(OFF_SW_CTRL) && mem_wdata[BIT_D0] |=> stopwatch_clear_strobe)
        else $error("stopwatch clear strobe missing");

    a_reload_strobe: assert property (@(posedge clock) disable iff (rst) // R17
        wr_at(OFF_PT_CTRL) && mem_wdata[BIT_D0] |=> timer_reload_strobe)
        else $error("timer reload strobe missing");

    a_page_alias: assert property (@(posedge clock) disable iff (rst) // R24
        mem_wr && off == OFF_PT_RLD_LO |=> timer_reload[3:0] == $past(mem_wdata))
        else $error("page alias write failed");

    // Read side
    a_unused_zero: assert property (@(posedge clock) disable iff (rst) // R23
        rd_at(OFF_LCD) |-> mem_rdata[BIT_D1] == 1'b0)
        else $error("unused bit read nonzero");

    a_strobe_reads_zero: assert property (@(posedge clock) disable iff (rst) // R15
        rd_at(OFF_SW_CTRL) |-> mem_rdata[BIT_D0] == 1'b0)
        else $error("clear strobe bit reads nonzero");

    a_reset_reads_zero: assert property (@(posedge clock) disable iff (rst) // R12
        rd_at(OFF_CT_RESET) |-> mem_rdata == 4'h0)
        else $error("timer reset word reads nonzero");


    c_flag_read: cover property (@(posedge clock) disable iff (rst) timer_flag_r && rd_at(OFF_TIMER_FLAG));
    c_irq_raised: cover property (@(posedge clock) disable iff (rst) $rose(irq_request));
    c_reload: cover property (@(posedge clock) disable iff (rst) timer_reload_strobe);
    c_set_on_clear: cover property (@(posedge clock) disable iff (rst) timer_event && rd_at(OFF_TIMER_FLAG));

endmodule
`default_nettype wire

// >>> sim/iomcr_cpu_model.sv
/*
 * CPU data-memory bus model for the I/O register bank: one read or write per call.
 * Assumes the bank answers reads combinationally and takes writes on the rising edge.
 */
`timescale 1ns/1ns
`default_nettype none
module iomcr_cpu_model (
    input wire logic clock,
    output logic [9:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [3:0] mem_wdata,
    input wire logic [3:0] mem_rdata,
    input wire logic mem_sel
);
    initial begin
        mem_addr = 10'h000;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_wdata = 4'h0;
    end

    // ==========================================
    // Bus access
    // Held across the taking edge, then released with inverted lines
    task automatic access(input logic [9:0] a, input logic wr, input logic [3:0] d, output logic [3:0] q,
                          output logic s);
        @(negedge clock);
        mem_addr = a;
        mem_wdata = d;
        mem_rd = ~wr;
        mem_wr = wr;
        @(posedge clock);
        q = mem_rdata;
        s = mem_sel;
        @(negedge clock);
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_addr = ~a;
        mem_wdata = ~d;
    endtask
endmodule
`default_nettype wire

// >>> sim/iomcr_regs_test.sv
/*
 * Self-checking bench for the I/O register bank, with an integer model of every register.
 * Assumes the CPU bus model in iomcr_cpu_model and one-cycle event pulses.
 */
`timescale 1ns/1ns
`default_nettype none
module iomcr_regs_test;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [9:0] mem_addr, a;
    logic mem_rd, mem_wr, mem_sel, irq_request, s;
    logic [3:0] mem_wdata, mem_rdata, q;
    logic [10:0] ev = 11'h000;
    logic [7:0] ct_st = 8'h00, tcount = 8'h00;
    logic [1:0] wd_st = 2'h0;
    logic [3:0] hund = 4'h0, tenth = 4'h0;
    logic [31:0] r, r2;
    wire [38:0] ctl;
    wire [3:0] stb;
    int regm[256] = '{default: 0};
    int fl[7] = '{default: 0};
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'h08b0;

    always #5 clock = ~clock;

    iomcr_regs u_iomcr_regs (
        .clock(clock), .rst(rst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_sel(mem_sel), .timer_event(ev[10]), .serial_event(ev[9]), .port1_event(ev[8]),
        .port0_event(ev[7]), .converter_event(ev[6]), .stopwatch_events(ev[5:4]), .clock_timer_events(ev[3:0]),
        .clock_stages(ct_st), .watchdog_stages(wd_st), .stopwatch_hundredths(hund), .stopwatch_tenths(tenth),
        .timer_count(tcount), .irq_request(irq_request), .periph_irq_enable(ctl[38:36]),
        .port_irq_enable(ctl[35:34]), .port0_line_select(ctl[33:30]), .stopwatch_irq_enable(ctl[29:28]),
        .clock_timer_irq_enable(ctl[27:24]), .out3_buzzer_route(ctl[23]), .out2_buzzer_route(ctl[22]),
        .buzzer_tone_select(ctl[21]), .out0_freq_route(ctl[20]), .freq_output_select(ctl[19:18]),
        .clock_timer_reset_strobe(stb[3]), .watchdog_reset_strobe(stb[2]), .stopwatch_run(ctl[17]),
        .stopwatch_clear_strobe(stb[1]), .out1_overflow_route(ctl[16]), .timer_run(ctl[15]),
        .timer_reload_strobe(stb[0]), .timer_prediv(ctl[14:13]), .timer_source(ctl[12:11]),
        .timer_reload(ctl[10:3]), .lcd_duty(ctl[2:1]), .lcd_display_on(ctl[0])
    );

    iomcr_cpu_model u_iomcr_cpu_model (
        .clock(clock), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_sel(mem_sel)
    );

    // ==========================================
    // Reference model
    function automatic int wmask(int off);
        case (off)
            8'hc8: return 7;
            8'hc9, 8'hcb: return 3;
            8'he6: return 2;
            8'hca, 8'hcc, 8'hea, 8'hed, 8'hee: return 15;
            8'he0, 8'hef: return 13;
            8'he1: return 11;
            8'he9: return 10;
            default: return 0;
        endcase
    endfunction

    function automatic int rd_exp(int off);
        if (off >= 8'hc0 && off <= 8'hc6) return fl[off - 8'hc0];
        case (off)
            8'he3: return ct_st[3:0];
            8'he4: return ct_st[7:4];
            8'he5: return wd_st;
            8'he7: return hund;
            8'he8: return tenth;
            8'heb: return tcount[3:0];
            8'hec: return tcount[7:4];
            default: return regm[off];
        endcase
    endfunction

    function automatic logic [38:0] out_exp();
        return {regm[8'hc8][2:0], regm[8'hc9][1:0], regm[8'hca][3:0], regm[8'hcb][1:0], regm[8'hcc][3:0],
                regm[8'he0][3:2], regm[8'he0][0], regm[8'he1][3], regm[8'he1][1:0], regm[8'he6][1],
                regm[8'he9][3], regm[8'he9][1], regm[8'hea][3:0], regm[8'hee][3:0], regm[8'hed][3:0],
                regm[8'hef][3:2], regm[8'hef][0]};
    endfunction

    function automatic logic irq_exp();
        return |{fl[0][0] & regm[8'hc8][0], fl[1][0] & regm[8'hc8][1], fl[4][0] & regm[8'hc8][2],
                 fl[2][0] & regm[8'hc9][1], fl[3][0] & regm[8'hc9][0], fl[5][1:0] & regm[8'hcb][1:0],
                 fl[6][3:0] & regm[8'hcc][3:0]};
    endfunction

    // ==========================================
    // Checking and bus tasks
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [9:0] ad, input logic [3:0] d);
        int off;
        logic [3:0] se;
        off = ad[7:0];
        se = 4'h0;
        u_iomcr_cpu_model.access(ad, 1'b1, d, q, s);
        regm[off] = (regm[off] & ~wmask(off)) | (d & wmask(off));
        if (off == 8'he2) se = {d[0], d[0], 2'b00};
        if (off == 8'he5) se[2] = d[3];
        if (off == 8'he6) se[1] = d[0];
        if (off == 8'he9) se[0] = d[0];
        chk("strobes", se, stb);
        chk("controls", out_exp(), ctl);
        chk("irq", irq_exp(), irq_request);
    endtask

    task automatic rd(input logic [9:0] ad);
        int off;
        off = ad[7:0];
        u_iomcr_cpu_model.access(ad, 1'b0, 4'h0, q, s);
        chk("rdata", rd_exp(off), q);
        chk("select", off >= 8'hc0, s);
        if (off >= 8'hc0 && off <= 8'hc6) fl[off - 8'hc0] = 0;
        chk("irq", irq_exp(), irq_request);
    endtask

    task automatic pulse(input logic [10:0] e);
        @(negedge clock);
        ev = e;
        @(negedge clock);
        ev = 11'h000;
        fl[0] |= e[10];
        fl[1] |= e[9];
        fl[2] |= e[8];
        fl[3] |= e[7];
        fl[4] |= e[6];
        fl[5] |= e[5:4];
        fl[6] |= e[3:0];
        chk("irq", irq_exp(), irq_request);
    endtask

    task automatic print_verdict();
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ==========================================
    // Scenarios
    initial begin
        repeat (16) @(negedge clock);
        rst = 1'b0;
        for (int o = 8'hc0; o < 256; o++) rd({2'b00, o[7:0]});
        for (int m = 8'hc8; m <= 8'hcc; m++) wr({2'b01, m[7:0]}, 4'hf);
        for (int m = 8'he0; m <= 8'hef; m++) wr({2'b11, m[7:0]}, 4'hf);
        for (int i = 0; i < 11; i++) begin
            pulse(11'h001 << i);
            for (int o = 8'hc0; o <= 8'hc6; o++) rd({2'b10, o[7:0]});
        end
        wr(10'h0c8, 4'h0);
        pulse(11'h400);
        for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            r2 = $random(seed);
            {ct_st, wd_st, hund, tenth, tcount} = r2[25:0];
            a = r[9:0];
            if (r[11:10] != 2'b00) a[7:6] = 2'b11;
            case (r[13:12])
                2'b00: pulse(r[24:14]);
                2'b10: wr(a, r[27:24]);
                default: rd(a);
            endcase
        end
        @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        regm = '{default: 0};
        fl = '{default: 0};
        chk("controls", out_exp(), ctl);
        chk("irq", irq_exp(), irq_request);
        rd(10'h3c6);
        print_verdict();
    end

    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
endmodule
`default_nettype wire
